// ---- rtl/acsi_consts.svh ----
// constants for the async serial comm interface
// assumes a single 200 MHz core clock and a byte-wide register port
`ifndef ACSI_CONSTS_SVH
`define ACSI_CONSTS_SVH
`define ACSI_ADDR_BAUD 8'h0D
`define ACSI_ADDR_FMT 8'h0E
`define ACSI_ADDR_CTL 8'h0F
`define ACSI_ADDR_STAT 8'h10
`define ACSI_ADDR_DATA 8'h11
`define ACSI_RST_BAUD 8'h00
`define ACSI_RST_FMT 8'h00
`define ACSI_RST_CTL 8'h00
`define ACSI_OVS_LAST 4'hF
`define ACSI_OVS_MID 4'h7
`define ACSI_OVS_S1 4'h6
`define ACSI_OVS_S3 4'h8
`define ACSI_BITS8 4'h9
`define ACSI_BITS9 4'hA
`define ACSI_PRE1 7'h00
`define ACSI_PRE3 7'h02
`define ACSI_PRE4 7'h03
`define ACSI_PRE13 7'h0C
`endif

// ---- rtl/acsi_pkg.sv ----
// types for the async serial comm interface
// assumes acsi_consts.svh supplies all numeric constants
package acsi_pkg;
    typedef enum logic [1:0] {
        ACSI_IDLE = 2'h0,
        ACSI_START = 2'h1,
        ACSI_DATA = 2'h3,
        ACSI_STOP = 2'h2
    } acsi_state_e;
    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic idle_irq_en;
        logic tx_on;
        logic rx_on;
        logic rx_sleep;
        logic send_break;
    } acsi_ctl_s;
    typedef struct packed {
        logic tx_buffer_empty;
        logic tx_done_flag;
        logic rx_buffer_full;
        logic idle;
        logic overrun;
        logic noise_flag;
        logic framing_error_flag;
        logic rsvd;
    } acsi_stat_s;
endpackage

// ---- rtl/acsi_top.sv ----
// async serial comm interface: transmitter, receiver, registers
// assumes a byte register port on CORE_CLK; RXD is asynchronous
// How it works
// RULE1: data address writes the transmit buffer, reads the receive buffer
// RULE2: each direction has a holding buffer beside its shifter
// RULE3: format bit set gives nine data bits, clear gives eight
// RULE4: line high is one, low is zero
// RULE5: line rests high when idle
// RULE6: every character opens with a low start bit
// RULE7: data bits go least significant first after the start bit
// RULE8: each character ends with a high stop bit
// RULE9: break is a low level of ten or eleven bit times
// RULE10: transmit enables gate buffer-empty and done flags to interrupt
// RULE11: receive enable gates full and overrun; idle enable gates idle
// RULE12: status holds two transmit flags and five receive flags
// RULE13: overrun, noise and framing errors are separate flags
// RULE14: receive buffer full sits in status bit 5
// RULE15: transmit buffer empty sits in status bit 7
// RULE16: writing 0x0C to control turns on transmitter and receiver only
// RULE17: transmitter-on and receiver-on bits enable each direction
// RULE18: software leaves sleep and break clear at setup
// RULE19: software sets divider, then format, then control
// RULE20: completed character moves to buffer; unread buffer means overrun
// RULE21: transmit flags are set by hardware and readable any time
// RULE22: receiver samples the line at sixteen times the bit rate
// RULE23: rate is prescale 1,3,4,13 then power of two up to 128
// RULE24: send-break sends all-zero characters including stop position
// RULE25: idle flag sets after a full character of high line
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "acsi_consts.svh"
`default_nettype none
module acsi_top (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // serial line
    input wire logic RXD,
    output logic TXD,
    // interrupt request
    output logic IRQ
);
    logic [7:0] baud;
    logic [7:0] fmt;
    acsi_pkg::acsi_ctl_s ctl;
    acsi_pkg::acsi_stat_s stat;
    logic [6:0] pre_cnt;
    logic [6:0] div_cnt;
    logic ovs_tick;
    logic [3:0] tx_ph;
    logic tx_bit_tick;
    logic [8:0] tx_hold;
    logic tx_empty;
    logic tx_done;
    logic [10:0] tx_shift;
    logic [3:0] tx_left;
    logic tx_busy;
    logic rx_s1, rx_s2;
    acsi_pkg::acsi_state_e rx_st;
    logic [3:0] rx_ph;
    logic [3:0] rx_idx;
    logic [8:0] rx_shift;
    logic [2:0] rx_smp;
    logic rx_nz;
    logic [8:0] rx_buf;
    logic rx_full, rx_idle, rx_over, rx_noise, rx_ferr;
    logic rx_seen;
    logic [3:0] idle_bits;
    logic [3:0] idle_ph;
    // decode
    wire nine = fmt[4]; // [RULE3]
    wire [3:0] n_bits = nine ? `ACSI_BITS9 : `ACSI_BITS8;
    wire wr_baud = WR && ADDR == `ACSI_ADDR_BAUD;
    wire wr_fmt = WR && ADDR == `ACSI_ADDR_FMT;
    wire wr_ctl = WR && ADDR == `ACSI_ADDR_CTL;
    wire wr_data = WR && ADDR == `ACSI_ADDR_DATA; // [RULE1]
    wire rd_stat = RD && ADDR == `ACSI_ADDR_STAT;
    wire rd_data = RD && ADDR == `ACSI_ADDR_DATA; // [RULE1]
    wire rx_end_bit = ovs_tick && rx_ph == `ACSI_OVS_LAST;
    wire rx_done_w = rx_st == acsi_pkg::ACSI_STOP && rx_end_bit;
    wire rx_sleep_w = ctl.rx_sleep;
    // prescaler and power-of-two divider give the 16x tick
    function automatic logic [6:0] pre_last(input logic [1:0] sel);
        case (sel)
            2'h0: pre_last = `ACSI_PRE1;
            2'h1: pre_last = `ACSI_PRE3;
            2'h2: pre_last = `ACSI_PRE4;
            default: pre_last = `ACSI_PRE13;
        endcase
    endfunction
    wire pre_tick = pre_cnt >= pre_last(baud[5:4]); // [RULE23]
    wire [6:0] div_last = 7'((8'h01 << baud[2:0]) - 8'h01); // [RULE23]
    wire ovs_hit = pre_tick && div_cnt >= div_last;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_cnt <= 7'h00;
            div_cnt <= 7'h00;
            ovs_tick <= 1'b0;
        end else begin
            pre_cnt <= pre_tick ? 7'h00 : pre_cnt + 7'h01;
            if (pre_tick)
                div_cnt <= ovs_hit ? 7'h00 : div_cnt + 7'h01;
            ovs_tick <= ovs_hit;
        end
    end
    // transmit bit tick: every sixteenth oversample tick
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_ph <= 4'h0;
        end else if (ovs_tick) begin
            tx_ph <= tx_ph + 4'h1;
        end
    end
    assign tx_bit_tick = ovs_tick && tx_ph == `ACSI_OVS_LAST;
    // registers
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            baud <= `ACSI_RST_BAUD;
            fmt <= `ACSI_RST_FMT;
            ctl <= `ACSI_RST_CTL;
        end else begin
            if (wr_baud)
                baud <= WDATA;
            if (wr_fmt)
                fmt <= {fmt[7], WDATA[6:0]};
            // ninth bit follows the buffer: dropped frames leave it alone
            if (rx_done_w && !rx_full && !rx_sleep_w)
                fmt[7] <= rx_shift[8]; // [RULE3]
            if (wr_ctl)
                ctl <= WDATA; // [RULE16] [RULE17]
        end
    end
    // transmitter
    wire tx_load = ctl.tx_on && !tx_busy && tx_bit_tick
        && (!tx_empty || ctl.send_break);
    wire [10:0] tx_frame = ctl.send_break ? 11'h000 // [RULE24] [RULE9]
        : nine ? {1'b1, fmt[6], tx_hold[7:0], 1'b0} // [RULE6] [RULE8]
        : {2'b11, tx_hold[7:0], 1'b0};
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_hold <= 9'h000;
            tx_empty <= 1'b1;
            tx_done <= 1'b1;
            tx_shift <= 11'h7FF;
            tx_left <= 4'h0;
            tx_busy <= 1'b0;
            TXD <= 1'b1; // [RULE5]
        end else begin
            if (wr_data) begin
                tx_hold <= {1'b0, WDATA}; // [RULE2]
                tx_empty <= 1'b0;
                tx_done <= 1'b0;
            end else if (tx_load && !ctl.send_break) begin
                tx_empty <= 1'b1; // [RULE21]
            end
            if (tx_load) begin
                tx_shift <= tx_frame;
                // count ends on the stop slot so a break is one character
                tx_left <= n_bits; // [RULE9]
                tx_busy <= 1'b1;
                TXD <= tx_frame[0];
            end else if (tx_busy && tx_bit_tick) begin
                tx_shift <= {1'b1, tx_shift[10:1]}; // [RULE7]
                TXD <= tx_left == 4'h0 ? 1'b1 : tx_shift[1]; // [RULE4]
                tx_left <= tx_left - 4'h1;
                if (tx_left == 4'h0) begin
                    tx_busy <= 1'b0;
                    if (tx_empty && !wr_data)
                        tx_done <= 1'b1; // [RULE21]
                end
            end else if (!tx_busy) begin
                TXD <= 1'b1; // [RULE5]
            end
        end
    end
    // receiver input synchroniser
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= RXD;
            rx_s2 <= rx_s1;
        end
    end
    // majority of three middle samples; disagreement flags noise
    wire [1:0] votes = 2'(rx_smp[0]) + 2'(rx_smp[1]) + 2'(rx_smp[2]);
    wire bit_val = votes >= 2'h2;
    wire bit_noisy = votes != 2'h0 && votes != 2'h3;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_st <= acsi_pkg::ACSI_IDLE;
            rx_ph <= 4'h0;
            rx_idx <= 4'h0;
            rx_shift <= 9'h000;
            rx_smp <= 3'h7;
            rx_nz <= 1'b0;
        end else if (!ctl.rx_on) begin
            rx_st <= acsi_pkg::ACSI_IDLE; // [RULE17]
        end else if (ovs_tick) begin // [RULE22]
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph >= `ACSI_OVS_S1 && rx_ph <= `ACSI_OVS_S3)
                rx_smp <= {rx_s2, rx_smp[2:1]};
            case (rx_st)
                acsi_pkg::ACSI_IDLE: begin
                    rx_ph <= 4'h0;
                    rx_nz <= 1'b0;
                    if (!rx_s2)
                        rx_st <= acsi_pkg::ACSI_START; // [RULE6]
                end
                acsi_pkg::ACSI_START: begin
                    if (rx_ph == `ACSI_OVS_MID && rx_s2)
                        rx_st <= acsi_pkg::ACSI_IDLE;
                    else if (rx_ph == `ACSI_OVS_LAST) begin
                        rx_st <= acsi_pkg::ACSI_DATA;
                        rx_idx <= 4'h0;
                    end
                end
                acsi_pkg::ACSI_DATA: begin
                    if (rx_ph == `ACSI_OVS_LAST) begin
                        rx_shift <= nine // [RULE7]
                            ? {bit_val, rx_shift[8:1]}
                            : {1'b0, bit_val, rx_shift[7:1]};
                        rx_nz <= rx_nz | bit_noisy;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == n_bits - 4'h2)
                            rx_st <= acsi_pkg::ACSI_STOP;
                    end
                end
                acsi_pkg::ACSI_STOP: begin
                    if (rx_ph == `ACSI_OVS_LAST)
                        rx_st <= acsi_pkg::ACSI_IDLE;
                end
                default: rx_st <= acsi_pkg::ACSI_IDLE;
            endcase
        end
    end
    // receive buffer and flags; a set wins over the read clear
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_buf <= 9'h000;
            rx_full <= 1'b0;
            rx_over <= 1'b0;
            rx_noise <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            if (rd_data)
                rx_full <= 1'b0;
            if (rd_data)
                rx_over <= 1'b0;
            if (rd_data)
                rx_noise <= 1'b0;
            if (rd_data)
                rx_ferr <= 1'b0;
            if (rx_done_w && !rx_sleep_w) begin
                if (rx_full) begin
                    rx_over <= 1'b1; // [RULE20] [RULE13]
                end else begin
                    rx_buf <= rx_shift; // [RULE2] [RULE20]
                    rx_full <= 1'b1;
                    rx_noise <= rx_nz | bit_noisy; // [RULE13]
                    rx_ferr <= !bit_val; // [RULE8] [RULE13]
                end
            end
        end
    end
    // idle line: a full character of high after activity
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_idle <= 1'b0;
            rx_seen <= 1'b0;
            idle_bits <= 4'h0;
            idle_ph <= 4'h0;
        end else begin
            if (rd_stat && rx_idle)
                rx_idle <= 1'b0;
            if (rx_st != acsi_pkg::ACSI_IDLE || !rx_s2) begin
                rx_seen <= 1'b1;
                idle_bits <= 4'h0;
                idle_ph <= 4'h0;
            end else if (ovs_tick && rx_seen) begin
                idle_ph <= idle_ph + 4'h1;
                if (idle_ph == `ACSI_OVS_LAST) begin
                    idle_bits <= idle_bits + 4'h1;
                    if (idle_bits == n_bits) begin
                        rx_idle <= 1'b1; // [RULE25]
                        rx_seen <= 1'b0;
                    end
                end
            end
        end
    end
    // status and read path
    always_comb begin
        stat = '0;
        stat.tx_buffer_empty = tx_empty; // [RULE15] [RULE12]
        stat.tx_done_flag = tx_done; // [RULE12]
        stat.rx_buffer_full = rx_full; // [RULE14]
        stat.idle = rx_idle;
        stat.overrun = rx_over;
        stat.noise_flag = rx_noise;
        stat.framing_error_flag = rx_ferr;
    end
    wire [7:0] rd_mux = ADDR == `ACSI_ADDR_BAUD ? baud
        : ADDR == `ACSI_ADDR_FMT ? fmt
        : ADDR == `ACSI_ADDR_CTL ? ctl
        : ADDR == `ACSI_ADDR_STAT ? stat
        : ADDR == `ACSI_ADDR_DATA ? rx_buf[7:0]
        : 8'h00;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)
            RDATA <= 8'h00;
        else if (RD)
            RDATA <= rd_mux;
    end
    // single request line; no controller of its own
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)
            IRQ <= 1'b0;
        else
            IRQ <= (ctl.tx_empty_irq_en && tx_empty) // [RULE10]
                || (ctl.tx_done_irq_en && tx_done) // [RULE10]
                || (ctl.rx_full_irq_en && (rx_full || rx_over)) // [RULE11]
                || (ctl.idle_irq_en && rx_idle); // [RULE11]
    end
endmodule // acsi_top
`default_nettype wire

// ---- verif/acsi_assertions.sv ----
// port checker for acsi_top
// assumes a bind to acsi_top and the map in acsi_consts.svh
`timescale 1ns/1ps
`include "acsi_consts.svh"
`default_nettype none
module acsi_chk (
    // clock, reset, register port
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // serial line and request
    input wire logic RXD,
    input wire logic TXD,
    input wire logic IRQ
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);
    logic [7:0] ctl_q;
    logic [3:0] run;
    logic txd_q;
    wire rd_st = RD && ADDR == `ACSI_ADDR_STAT;
    wire hole = ADDR < `ACSI_ADDR_BAUD || ADDR > `ACSI_ADDR_DATA;
    // run saturates: only the shortest bit time matters
    wire [3:0] next_run = (TXD != txd_q) ? 4'h0 :
        (run == 4'hF) ? run : run + 4'h1;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctl_q <= `ACSI_RST_CTL;
            run <= 4'hF;
            txd_q <= 1'b1;
        end else begin
            ctl_q <= (WR && ADDR == `ACSI_ADDR_CTL) ? WDATA : ctl_q;
            run <= next_run;
            txd_q <= TXD;
        end
    end
    sequence data_wr;
        WR && ADDR == `ACSI_ADDR_DATA;
    endsequence
    chk_reset_line_idle: assert property ($rose(RSTN) |-> TXD [*3])
        else $error("line not idle after reset");
    chk_write_fills: assert property (data_wr ##1 rd_st |=> !RDATA[7])
        else $error("empty flag still set after data write");
    chk_hole_zero: assert property (RD && hole |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_rsvd_zero: assert property (rd_st |=> !RDATA[0])
        else $error("status spare bit set");
    chk_ctl_readback: assert property (RD && ADDR == `ACSI_ADDR_CTL
        |=> RDATA == $past(ctl_q)) else $error("control readback wrong");
    chk_irq_masked: assert property ((ctl_q[7:4] == 4'h0) [*3] |-> !IRQ)
        else $error("request with all enables off");
    chk_irq_tx_empty: assert property (rd_st && ctl_q[7] ##1 RDATA[7]
        |-> IRQ) else $error("empty flag enabled but no request");
    chk_bit_width: assert property (TXD != txd_q |-> run == 4'hF)
        else $error("line bit shorter than sixteen cycles");
endmodule // acsi_chk
bind acsi_top acsi_chk u_acsi_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
`default_nettype wire

// ---- verif/acsi_term.sv ----
// remote terminal on the serial line
// assumes the fastest rate: sixteen core cycles a bit
`timescale 1ns/1ps
`default_nettype none
module acsi_term (
    // clock
    input wire logic clk,
    // serial line
    input wire logic line_in,
    output logic line_out
);
    int bit_cycles = 16;
    logic nine = 1'b0;
    logic [8:0] got[$];
    initial line_out = 1'b1;
    task automatic send(input logic [8:0] d, input logic stop);
        @(posedge clk);
        line_out <= 1'b0;
        repeat (bit_cycles) @(posedge clk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            line_out <= d[i];
            repeat (bit_cycles) @(posedge clk);
        end
        line_out <= stop;
        repeat (bit_cycles) @(posedge clk);
        line_out <= 1'b1;
    endtask
    // frames with a low stop, break included, are dropped
    always begin : rx_mon
        logic [8:0] v;
        @(negedge line_in);
        v = 9'h000;
        repeat (bit_cycles / 2) @(posedge clk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_cycles) @(posedge clk);
            v[i] = line_in;
        end
        repeat (bit_cycles) @(posedge clk);
        if (line_in === 1'b1) got.push_back(v);
    end
endmodule // acsi_term
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for acsi_top with a terminal model
// assumes the register map in acsi_consts.svh
`timescale 1ns/1ps
`include "acsi_consts.svh"
`default_nettype none
module tb_top;
    logic core_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, s;
    logic rxd, txd, irq;
    int failures = 0, compares = 0;
    acsi_top u_acsi_top (.CORE_CLK(core_clk), .RSTN(rstn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RXD(rxd),
        .TXD(txd), .IRQ(irq));
    acsi_term u_acsi_term (.clk(core_clk), .line_in(txd), .line_out(rxd));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    // data stand from the cycle after the strobe until the next read strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        s = rdata;
    endtask
    // write then read with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
        input logic [7:0] b);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        addr <= b;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        s = rdata;
    endtask
    task automatic ck(input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        rd_reg(a);
        check({1'b0, s & m}, {1'b0, e});
    endtask
    task automatic wait_st(input int b);
        for (int n = 0; n < 3000; n++) begin
            rd_reg(`ACSI_ADDR_STAT);
            if (s[b] === 1'b1) return;
        end
        failures++;
        close_out();
    endtask
    task automatic wait_got(input int n);
        for (int k = 0; k < 8000; k++) begin
            if (u_acsi_term.got.size() >= n) return;
            @(posedge core_clk);
        end
        failures++;
        close_out();
    endtask
    task automatic t_setup();
        ck(`ACSI_ADDR_STAT, 8'hFF, 8'hC0);
        ck(`ACSI_ADDR_CTL, 8'hFF, 8'h00);
        wr_reg(8'h20, 8'hFF);
        ck(8'h20, 8'hFF, 8'h00);
        wr_reg(`ACSI_ADDR_BAUD, 8'h00);
        wr_reg(`ACSI_ADDR_FMT, 8'h00);
        wr_reg(`ACSI_ADDR_CTL, 8'h0C);
        ck(`ACSI_ADDR_CTL, 8'hFF, 8'h0C);
        $display("test setup done");
    endtask
    task automatic t_tx();
        wr_reg(`ACSI_ADDR_DATA, 8'h5A);
        wait_st(7);
        wr_rd(`ACSI_ADDR_DATA, 8'hA5, `ACSI_ADDR_STAT);
        check({1'b0, s & 8'h80}, 9'h000);
        wait_got(2);
        check(u_acsi_term.got[0], 9'h05A);
        check(u_acsi_term.got[1], 9'h0A5);
        repeat (20) @(posedge core_clk);
        ck(`ACSI_ADDR_STAT, 8'hC0, 8'hC0);
        $display("test transmit done");
    endtask
    task automatic t_rx();
        u_acsi_term.send(9'h03C, 1'b1);
        wait_st(5);
        ck(`ACSI_ADDR_DATA, 8'hFF, 8'h3C);
        u_acsi_term.send(9'h011, 1'b1);
        u_acsi_term.send(9'h022, 1'b1);
        repeat (200) @(posedge core_clk);
        ck(`ACSI_ADDR_STAT, 8'h3E, 8'h38);
        ck(`ACSI_ADDR_DATA, 8'hFF, 8'h11);
        ck(`ACSI_ADDR_STAT, 8'h3E, 8'h00);
        u_acsi_term.send(9'h055, 1'b0);
        repeat (40) @(posedge core_clk);
        ck(`ACSI_ADDR_STAT, 8'h02, 8'h02);
        rd_reg(`ACSI_ADDR_DATA);
        // sleeping receiver drops the frame
        wr_reg(`ACSI_ADDR_CTL, 8'h0E);
        u_acsi_term.send(9'h066, 1'b1);
        repeat (40) @(posedge core_clk);
        ck(`ACSI_ADDR_STAT, 8'h20, 8'h00);
        wr_reg(`ACSI_ADDR_CTL, 8'h0C);
        $display("test receive done");
    endtask
    task automatic t_nine();
        u_acsi_term.got.delete();
        u_acsi_term.nine = 1'b1;
        wr_reg(`ACSI_ADDR_FMT, 8'h50);
        wr_reg(`ACSI_ADDR_DATA, 8'h81);
        wait_got(1);
        check(u_acsi_term.got[0], 9'h181);
        u_acsi_term.send(9'h1A5, 1'b1);
        wait_st(5);
        ck(`ACSI_ADDR_FMT, 8'h80, 8'h80);
        ck(`ACSI_ADDR_DATA, 8'hFF, 8'hA5);
        wr_reg(`ACSI_ADDR_FMT, 8'h00);
        u_acsi_term.nine = 1'b0;
        $display("test nine bits done");
    endtask
    task automatic t_irq_break();
        int lo = 0;
        wr_reg(`ACSI_ADDR_CTL, 8'h8C);
        ck(`ACSI_ADDR_STAT, 8'h80, 8'h80);
        check({8'h00, irq}, 9'h001);
        wr_reg(`ACSI_ADDR_CTL, 8'h4C);
        repeat (3) @(posedge core_clk);
        check({8'h00, irq}, 9'h001);
        wr_reg(`ACSI_ADDR_CTL, 8'h2C);
        repeat (3) @(posedge core_clk);
        check({8'h00, irq}, 9'h000);
        u_acsi_term.send(9'h077, 1'b1);
        wait_st(5);
        check({8'h00, irq}, 9'h001);
        ck(`ACSI_ADDR_DATA, 8'hFF, 8'h77);
        repeat (3) @(posedge core_clk);
        check({8'h00, irq}, 9'h000);
        // idle needs a quiet character after the last frame
        wr_reg(`ACSI_ADDR_CTL, 8'h1C);
        repeat (200) @(posedge core_clk);
        check({8'h00, irq}, 9'h001);
        wr_reg(`ACSI_ADDR_CTL, 8'h0D);
        for (int k = 0; k < 600; k++) begin
            @(posedge core_clk);
            if (txd === 1'b0)
                lo++;
            else if (lo > 0)
                break;
        end
        // ten bit times of sixteen cycles, no more
        check(9'(lo), 9'h0A0);
        wr_reg(`ACSI_ADDR_CTL, 8'h0C);
        repeat (400) @(posedge core_clk);
        check({8'h00, txd}, 9'h001);
        $display("test request and break done");
    endtask
    task automatic t_rate();
        int lo = 0;
        u_acsi_term.got.delete();
        u_acsi_term.bit_cycles = 96;
        wr_reg(`ACSI_ADDR_BAUD, 8'h11);
        wr_reg(`ACSI_ADDR_DATA, 8'h01);
        for (int k = 0; k < 400; k++) begin
            @(posedge core_clk);
            if (txd === 1'b0)
                lo++;
            else if (lo > 0)
                break;
        end
        // start bit: sixteen ticks of prescale three times two
        check(9'(lo), 9'h060);
        wait_got(1);
        check(u_acsi_term.got[0], 9'h001);
        $display("test rate done");
    endtask
    task automatic t_reset();
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        check({8'h00, txd}, 9'h001);
        ck(`ACSI_ADDR_STAT, 8'hFF, 8'hC0);
        ck(`ACSI_ADDR_BAUD, 8'h30, 8'h00);
        ck(`ACSI_ADDR_CTL, 8'hFF, 8'h00);
        $display("test reset done");
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        t_setup();
        t_tx();
        t_rx();
        t_nine();
        t_irq_break();
        t_rate();
        t_reset();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
